// [design/tni_pkg.sv]
// Constants, register map and rate table for the transmit null-insertion block
package tni_pkg;

    localparam int TNI_SMP_W = 32;
    localparam int TNI_FIFO_DEPTH = 16;

    localparam logic [15:0] TNI_ADDR_ISO_CTRL = 16'h2505;
    localparam logic [15:0] TNI_ADDR_SRATE = 16'h2506;
    localparam logic [15:0] TNI_ADDR_LINK_RES = 16'h2507;

    localparam logic [7:0] TNI_ISO_CTRL_RST = 8'h04;
    localparam logic [7:0] TNI_SRATE_RST = 8'hCC;
    localparam logic [7:0] TNI_LINK_RES_RST = 8'h3F;

    localparam int TNI_RSYNC_BIT = 6;
    localparam int TNI_POS_MSB = 5;
    localparam int TNI_POS_LSB = 3;
    localparam int TNI_STYLE_BIT = 2;
    localparam int TNI_MODE_MSB = 1;
    localparam int TNI_MODE_LSB = 0;
    localparam int TNI_RATE_MSB = 4;
    localparam int TNI_RATE_LSB = 0;
    localparam int TNI_SRATE_RSVD_LSB = 5;
    localparam int TNI_DIG_RES_LSB = 4;
    localparam int TNI_CAP_RES_LSB = 2;
    localparam int TNI_PLAY_RES_LSB = 0;

    localparam logic [2:0] TNI_SRATE_RSVD = 3'h6;
    localparam logic [7:0] TNI_RDATA_NONE = 8'h00;

    localparam logic [1:0] TNI_MODE_NATIVE = 2'h0;
    localparam logic [1:0] TNI_MODE_ISO96 = 2'h2;
    localparam logic [1:0] TNI_MODE_ISO192 = 2'h3;
    localparam logic TNI_STYLE_WHOLE = 1'h1;
    localparam logic TNI_STYLE_BYTE = 1'h0;

    localparam logic [1:0] TNI_RES_20 = 2'h0;
    localparam logic [1:0] TNI_RES_16 = 2'h1;
    localparam logic [1:0] TNI_RES_24 = 2'h2;
    localparam logic [1:0] TNI_RES_32 = 2'h3;
    localparam logic [1:0] TNI_CAP_RES_8 = 2'h0;

    localparam logic [5:0] TNI_W_8 = 6'h08;
    localparam logic [5:0] TNI_W_16 = 6'h10;
    localparam logic [5:0] TNI_W_20 = 6'h14;
    localparam logic [5:0] TNI_W_24 = 6'h18;
    localparam logic [5:0] TNI_W_32 = 6'h20;

    localparam int TNI_NB_LSB_16 = 16;
    localparam int TNI_NB_LSB_24 = 8;
    localparam logic [7:0] TNI_NB_MARK = 8'h01;
    localparam logic [7:0] TNI_NB_NULL = 8'h00;
    localparam logic [31:0] TNI_LANE_MASK = 32'h000000FF;

    localparam logic [4:0] TNI_RATE_CODE_8K = 5'h01;
    localparam logic [4:0] TNI_RATE_CODE_48K = 5'h0C;
    localparam logic [4:0] TNI_RATE_CODE_192K = 5'h12;

    // Rates in units of 10 Hz
    localparam logic [14:0] TNI_RATE_BASE = 15'h12C0;

    typedef enum logic {TNI_ST_RUN, TNI_ST_RESYNC} tni_state_t;

    // Nominal rate per code; reserved codes fall back to the base rate
    function automatic logic [14:0] tni_rate_10hz(input logic [4:0] code);
        logic [14:0] r;
        r = TNI_RATE_BASE;
        case (code)
            5'h01: r = 15'h0320;
            5'h02: r = 15'h044F;
            5'h03: r = 15'h044F;
            5'h04: r = 15'h04B0;
            5'h05: r = 15'h0640;
            5'h06: r = 15'h089D;
            5'h07: r = 15'h089E;
            5'h08: r = 15'h0960;
            5'h09: r = 15'h0C80;
            5'h0A: r = 15'h113A;
            5'h0B: r = 15'h113C;
            5'h0C: r = 15'h12C0;
            5'h0D: r = 15'h2274;
            5'h0E: r = 15'h2278;
            5'h0F: r = 15'h2580;
            5'h10: r = 15'h44E8;
            5'h11: r = 15'h44EF;
            5'h12: r = 15'h4B00;
            default: r = TNI_RATE_BASE;
        endcase
        return r;
    endfunction

    function automatic logic [5:0] tni_res_width(input logic [1:0] code, input logic capture);
        logic [5:0] w;
        w = TNI_W_32;
        case (code)
            TNI_RES_20: w = capture ? TNI_W_8 : TNI_W_20;
            TNI_RES_16: w = TNI_W_16;
            TNI_RES_24: w = TNI_W_24;
            default: w = TNI_W_32;
        endcase
        return w;
    endfunction

endpackage

// [design/tni_fmt_if.sv]
// Carrier between the output stage and the null-word formatter
`timescale 1ns/1ps
interface tni_fmt_if;
    logic [1:0] mode;
    logic style;
    logic [2:0] pos;
    logic [1:0] res;
    logic [31:0] sample;
    logic is_null;
    logic [31:0] word;
    logic byte_style;

    modport src (output mode, output style, output pos, output res, output sample, output is_null,
                 input word, input byte_style);
    modport fmt (input mode, input style, input pos, input res, input sample, input is_null,
                 output word, output byte_style);
endinterface

// [design/tni_fifo.sv]
// Outgoing data FIFO with resync gating
`timescale 1ns/1ps
module tni_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_resync,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int AW = $clog2(DEPTH);

    initial
    begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
            $error("tni_fifo: DEPTH must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_r;
    logic [AW:0] rd_ptr_r;
    logic full;
    logic empty;
    logic push;
    logic pop;

    assign empty = (wr_ptr_r == rd_ptr_r);
    assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    assign o_in_ready = !full && !i_resync;
    assign o_out_valid = !empty && !i_resync;
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    assign o_out_data = mem[rd_ptr_r[AW-1:0]];

    // Pointers clear to zero while resync holds
    always_ff @(posedge i_clk)
    begin
        if (i_rst || i_resync)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_r <= wr_ptr_r + 1'b1;
            if (pop)
                rd_ptr_r <= rd_ptr_r + 1'b1;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (push)
            mem[wr_ptr_r[AW-1:0]] <= i_in_data;
    end
endmodule

// [design/tni_fmt.sv]
// Builds the transmitted word, inserting the null byte or null sample
`timescale 1ns/1ps
module tni_fmt
    import tni_pkg::*;
(
    tni_fmt_if.fmt fmt
);
    int lane_lsb;
    logic [7:0] nbyte;
    logic [31:0] mask;

    always_comb
    begin
        lane_lsb = TNI_NB_LSB_24;
        nbyte = TNI_NB_NULL;
        mask = '0;
        // Byte style only off native mode and never on 32-bit samples
        fmt.byte_style = (fmt.style == TNI_STYLE_BYTE) && fmt.mode[TNI_MODE_MSB]
                         && (fmt.res == TNI_RES_16 || fmt.res == TNI_RES_24);
        if (fmt.res == TNI_RES_16)
            lane_lsb = TNI_NB_LSB_16;
        else
            lane_lsb = TNI_NB_LSB_24;
        // Marker bit set in audio samples, clear in nulls
        nbyte = fmt.is_null ? TNI_NB_NULL : (TNI_NB_MARK << fmt.pos);
        mask = TNI_LANE_MASK << lane_lsb;
        if (fmt.byte_style)
            fmt.word = fmt.is_null ? ({24'h000000, nbyte} << lane_lsb)
                                   : ((fmt.sample & ~mask) | ({24'h000000, nbyte} << lane_lsb));
        else
            fmt.word = fmt.is_null ? '0 : fmt.sample;
    end
endmodule

// [design/tni_top.sv]
// Transmit isochronous null insertion with its configuration registers
// Function
// - Resync bit holds the outgoing FIFO in resync; reads and writes gated off.
// - Three-bit null position field selects the marker bit within the null byte.
// - Byte-null lane is [23:16] for 16-bit, [15:8] for 24-bit; 32-bit has no byte-null lane.
// - Byte-null style is not used with 32-bit samples.
// - With position zero, a null sample has bit 0 of its null byte clear.
// - Style bit: 1 whole-sample null (reset), 0 byte-null, only off native mode.
// - Mode field: 00 native, 10 96k isochronous, 11 192k isochronous.
// - Nulls inserted only in isochronous mode; rate setting only picks null slots.
// - Rate setting scales relative to the 48 kHz isochronous base.
// - Rate codes: 01 is 8 kHz, 0C is 48 kHz reset, 12 is 192 kHz; 00 and codes above 12 reserved.
// - Playback link resolution 00 20, 01 16, 10 24, 11 32 bits; reset 11.
`timescale 1ns/1ps
module tni_top
    import tni_pkg::*;
#(
    parameter int FIFO_DEPTH = TNI_FIFO_DEPTH
) (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic [15:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_ack,
    input wire logic i_smp_valid,
    input wire logic [TNI_SMP_W-1:0] i_smp_data,
    output logic o_smp_ready,
    output logic o_out_valid,
    output logic [TNI_SMP_W-1:0] o_out_data,
    output logic o_out_null,
    input wire logic i_out_ready,
    output logic [1:0] o_digital_out_resolution,
    output logic [5:0] o_capture_link_width,
    output logic [5:0] o_playback_link_width,
    output logic o_tx_fifo_resync
);
    initial
    begin
        if (FIFO_DEPTH < 2)
            $error("tni_top: FIFO_DEPTH too small");
    end

    logic [6:0] iso_ctrl_r;
    logic [4:0] tx_rate_setting_r;
    logic [5:0] link_res_r;
    logic [7:0] rdata_r;
    logic ack_r;
    tni_state_t state_r;
    tni_state_t state_nxt;
    logic [14:0] acc_r;
    logic [14:0] acc_nxt;
    logic out_valid_r;
    logic [TNI_SMP_W-1:0] out_data_r;
    logic out_null_r;
    logic [5:0] play_width_r;
    logic [5:0] cap_width_r;

    logic tx_fifo_resync;
    logic [2:0] tx_null_bit_position;
    logic tx_null_style_select;
    logic [1:0] tx_isochronous_mode;
    logic [1:0] playback_link_resolution;
    logic [1:0] capture_link_resolution;
    logic iso;
    logic [14:0] rate_10hz;
    logic [14:0] rate_eff;
    logic [15:0] acc_sum;
    logic data_slot;
    logic slot_take;
    logic use_data;
    logic load;
    logic fifo_valid;
    logic fifo_pop;
    logic [TNI_SMP_W-1:0] fifo_data;

    tni_fmt_if fmt_bus ();

    // Control and link resolution register fields
    assign tx_fifo_resync = iso_ctrl_r[TNI_RSYNC_BIT];
    assign tx_null_bit_position = iso_ctrl_r[TNI_POS_MSB:TNI_POS_LSB];
    assign tx_null_style_select = iso_ctrl_r[TNI_STYLE_BIT];
    assign tx_isochronous_mode = iso_ctrl_r[TNI_MODE_MSB:TNI_MODE_LSB];
    assign playback_link_resolution = link_res_r[TNI_PLAY_RES_LSB +: 2];
    assign capture_link_resolution = link_res_r[TNI_CAP_RES_LSB +: 2];

    // Register writes
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            iso_ctrl_r <= TNI_ISO_CTRL_RST[6:0];
            tx_rate_setting_r <= TNI_SRATE_RST[TNI_RATE_MSB:TNI_RATE_LSB];
            link_res_r <= TNI_LINK_RES_RST[5:0];
        end
        else if (i_reg_wr)
        begin
            case (i_reg_addr)
                TNI_ADDR_ISO_CTRL: iso_ctrl_r <= i_reg_wdata[6:0];
                TNI_ADDR_SRATE: tx_rate_setting_r <= i_reg_wdata[TNI_RATE_MSB:TNI_RATE_LSB];
                TNI_ADDR_LINK_RES: link_res_r <= i_reg_wdata[5:0];
                default: ;
            endcase
        end
    end

    // Register reads; reserved bits as their reset pattern
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            rdata_r <= TNI_RDATA_NONE;
            ack_r <= 1'b0;
        end
        else
        begin
            ack_r <= i_reg_wr || i_reg_rd;
            if (i_reg_rd)
            begin
                case (i_reg_addr)
                    TNI_ADDR_ISO_CTRL: rdata_r <= {1'b0, iso_ctrl_r};
                    TNI_ADDR_SRATE: rdata_r <= {TNI_SRATE_RSVD, tx_rate_setting_r};
                    TNI_ADDR_LINK_RES: rdata_r <= {2'b00, link_res_r};
                    default: rdata_r <= TNI_RDATA_NONE;
                endcase
            end
        end
    end

    assign o_reg_rdata = rdata_r;
    assign o_reg_ack = ack_r;

    assign o_digital_out_resolution = link_res_r[TNI_DIG_RES_LSB +: 2];
    assign o_playback_link_width = play_width_r;
    assign o_capture_link_width = cap_width_r;
    assign o_tx_fifo_resync = (state_r == TNI_ST_RESYNC);

    // Registered link widths
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            play_width_r <= TNI_W_32;
            cap_width_r <= TNI_W_32;
        end
        else
        begin
            play_width_r <= tni_res_width(playback_link_resolution, 1'b0);
            cap_width_r <= tni_res_width(capture_link_resolution, 1'b1);
        end
    end

    // Outgoing data FIFO
    tni_fifo #(
        .WIDTH(TNI_SMP_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_core_clk),
        .i_rst(i_sys_rst),
        .i_resync(tx_fifo_resync),
        .i_in_valid(i_smp_valid),
        .o_in_ready(o_smp_ready),
        .i_in_data(i_smp_data),
        .o_out_valid(fifo_valid),
        .o_out_data(fifo_data),
        .i_out_ready(fifo_pop)
    );

    // Resync state follows the control bit
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            TNI_ST_RUN: if (tx_fifo_resync) state_nxt = TNI_ST_RESYNC;
            TNI_ST_RESYNC: if (!tx_fifo_resync) state_nxt = TNI_ST_RUN;
            default: state_nxt = TNI_ST_RUN;
        endcase
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
            state_r <= TNI_ST_RUN;
        else
            state_r <= state_nxt;
    end

    // Slot scheduling: data share of slots is setting over the 48 kHz base
    assign iso = tx_isochronous_mode[TNI_MODE_MSB];
    assign rate_10hz = tni_rate_10hz(tx_rate_setting_r);
    assign rate_eff = (rate_10hz > TNI_RATE_BASE) ? TNI_RATE_BASE : rate_10hz;
    assign acc_sum = {1'b0, acc_r} + {1'b0, rate_eff};
    assign data_slot = (acc_sum >= {1'b0, TNI_RATE_BASE});
    assign slot_take = !tx_fifo_resync && (state_r == TNI_ST_RUN) && (!out_valid_r || i_out_ready);
    assign use_data = iso ? (data_slot && fifo_valid) : fifo_valid;
    assign fifo_pop = slot_take && use_data;
    assign load = slot_take && (iso || fifo_valid);

    always_comb
    begin
        acc_nxt = acc_r;
        if (slot_take && iso)
        begin
            if (data_slot && fifo_valid)
                acc_nxt = 15'(acc_sum - {1'b0, TNI_RATE_BASE});
            else if (!data_slot)
                acc_nxt = acc_sum[14:0];
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst || tx_fifo_resync || !iso)
            acc_r <= '0;
        else
            acc_r <= acc_nxt;
    end

    // Null-word formatter
    assign fmt_bus.mode = tx_isochronous_mode;
    assign fmt_bus.style = tx_null_style_select;
    assign fmt_bus.pos = tx_null_bit_position;
    assign fmt_bus.res = playback_link_resolution;
    assign fmt_bus.sample = fifo_data;
    assign fmt_bus.is_null = !use_data;

    tni_fmt u_fmt (
        .fmt(fmt_bus.fmt)
    );

    // Output stage
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst || tx_fifo_resync)
            out_valid_r <= 1'b0;
        else if (load)
            out_valid_r <= 1'b1;
        else if (i_out_ready)
            out_valid_r <= 1'b0;
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            out_data_r <= '0;
            out_null_r <= 1'b0;
        end
        else if (load)
        begin
            out_data_r <= iso ? fmt_bus.word : fifo_data;
            out_null_r <= iso && !use_data;
        end
    end

    assign o_out_valid = out_valid_r;
    assign o_out_data = out_data_r;
    assign o_out_null = out_null_r;

    // Checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);

    a_resync_gates_fifo: assert property (tx_fifo_resync |-> !o_smp_ready && !fifo_pop)
        else $error("FIFO not gated during resync");

    a_resync_out_idle: assert property (tx_fifo_resync |=> !o_out_valid && o_tx_fifo_resync)
        else $error("Output active during resync");

    a_resync_left_idle: assert property ($fell(tx_fifo_resync) |-> !o_out_valid)
        else $error("Output active as resync ends");

    a_resync_state_ret: assert property (!tx_fifo_resync && o_tx_fifo_resync |=> !o_tx_fifo_resync)
        else $error("Resync state not left");

    a_null_lane_16: assert property (fmt_bus.byte_style && !fmt_bus.is_null && fmt_bus.res == TNI_RES_16
        |-> fmt_bus.word[23:16] == (TNI_NB_MARK << fmt_bus.pos))
        else $error("Null byte wrong for 16-bit sample");

    a_null_lane_24: assert property (fmt_bus.byte_style && fmt_bus.res == TNI_RES_24
        |-> fmt_bus.word[15:8] == (fmt_bus.is_null ? TNI_NB_NULL : (TNI_NB_MARK << fmt_bus.pos)))
        else $error("Null byte wrong for 24-bit sample");

    a_no_byte_32: assert property (fmt_bus.res == TNI_RES_32 |-> !fmt_bus.byte_style)
        else $error("Byte-null used with 32-bit sample");

    a_whole_32: assert property (fmt_bus.res == TNI_RES_32 && !fmt_bus.is_null |-> fmt_bus.word == fmt_bus.sample)
        else $error("32-bit sample altered");

    a_pos_zero_null: assert property (fmt_bus.byte_style && fmt_bus.pos == 3'h0 && fmt_bus.res == TNI_RES_16
        |-> fmt_bus.word[16] == !fmt_bus.is_null)
        else $error("Bit 0 of null byte wrong");

    a_style_native: assert property (!iso || tx_null_style_select |-> !fmt_bus.byte_style)
        else $error("Byte-null outside isochronous mode");

    a_whole_null_zero: assert property (!fmt_bus.byte_style && fmt_bus.is_null |-> fmt_bus.word == '0)
        else $error("Whole null not zero");

    a_native_no_null: assert property (slot_take && !iso |=> !(o_out_valid && o_out_null))
        else $error("Null inserted in native mode");

    a_iso192_loads: assert property (slot_take && tx_isochronous_mode == TNI_MODE_ISO192 |-> load)
        else $error("192k slot not filled");

    a_native_passes: assert property (slot_take && !iso && fifo_valid |-> fifo_pop ##1 o_out_data == $past(fifo_data))
        else $error("Native sample not passed through");

    a_iso_null_slot: assert property (slot_take && iso && !data_slot |-> load && !fifo_pop)
        else $error("Null slot took data");

    a_native_data_only: assert property (load && !iso |=> !o_out_null)
        else $error("Native word marked null");

    a_full_rate_data: assert property (slot_take && iso && rate_eff == TNI_RATE_BASE && fifo_valid |-> fifo_pop)
        else $error("Base-rate setting inserted a null");

    a_rate_codes: assert property (tx_rate_setting_r == TNI_RATE_CODE_48K |-> rate_10hz == TNI_RATE_BASE)
        else $error("48 kHz code misdecoded");

    a_rsvd_codes: assert property (tx_rate_setting_r > TNI_RATE_CODE_192K |-> rate_10hz == TNI_RATE_BASE)
        else $error("Reserved code misdecoded");

    a_play_width: assert property (playback_link_resolution == TNI_RES_16 |=> o_playback_link_width == TNI_W_16)
        else $error("Playback width misdecoded");

    a_play_w32: assert property (playback_link_resolution == TNI_RES_32 |=> o_playback_link_width == TNI_W_32)
        else $error("Playback 32-bit width misdecoded");

    a_cap_width: assert property (capture_link_resolution == TNI_CAP_RES_8 |=> o_capture_link_width == TNI_W_8)
        else $error("Capture width misdecoded");

    c_resync: cover property ($rose(tx_fifo_resync) ##[1:20] $fell(tx_fifo_resync));
    c_iso192: cover property (load && tx_isochronous_mode == TNI_MODE_ISO192);
    c_null_out: cover property (o_out_valid && o_out_null && i_out_ready);
    c_byte_style: cover property (load && fmt_bus.byte_style && !use_data);
    c_fifo_full: cover property (i_smp_valid && !o_smp_ready && !tx_fifo_resync);
endmodule

// [sim/tni_host_model.sv]
// Host-side consumer of the transmitted word stream, with stall control
`timescale 1ns/1ps
module tni_host_model
    import tni_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_hold,
    input wire logic i_out_valid,
    input wire logic [TNI_SMP_W-1:0] i_out_data,
    input wire logic i_out_null,
    output logic o_out_ready
);
    logic [TNI_SMP_W:0] q[$];

    // Ready follows the stall request one cycle late, like a busy host
    always @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            o_out_ready <= 1'h0;
        end
        else
        begin
            o_out_ready <= !i_hold;
            if (i_out_valid && o_out_ready)
            begin
                q.push_back({i_out_null, i_out_data});
            end
        end
    end
endmodule

// [sim/tb.sv]
// Self-checking testbench for the transmit null-insertion block
`timescale 1ns/1ps
module tb
    import tni_pkg::*;
;
    logic i_core_clk = 1'h0;
    logic i_sys_rst = 1'h1;
    logic [15:0] i_reg_addr = 16'h0000;
    logic i_reg_wr = 1'h0;
    logic i_reg_rd = 1'h0;
    logic [7:0] i_reg_wdata = 8'h00;
    logic i_smp_valid = 1'h0;
    logic [31:0] i_smp_data = 32'h00000000;
    logic hold = 1'h1;
    logic [7:0] o_reg_rdata;
    logic o_reg_ack, o_smp_ready, o_out_valid, o_out_null, i_out_ready, o_tx_fifo_resync;
    logic [31:0] o_out_data;
    logic [1:0] o_digital_out_resolution;
    logic [5:0] o_capture_link_width, o_playback_link_width;
    int err_total = 0;
    int total_checks = 0;
    int cycles = 0;
    int n;
    logic ok;
    logic [32:0] e;
    localparam int DEPTH = 16;

    tni_top #(.FIFO_DEPTH(DEPTH)) DUT (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
        .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata), .o_reg_ack(o_reg_ack), .i_smp_valid(i_smp_valid),
        .i_smp_data(i_smp_data), .o_smp_ready(o_smp_ready), .o_out_valid(o_out_valid),
        .o_out_data(o_out_data), .o_out_null(o_out_null), .i_out_ready(i_out_ready),
        .o_digital_out_resolution(o_digital_out_resolution), .o_capture_link_width(o_capture_link_width),
        .o_playback_link_width(o_playback_link_width), .o_tx_fifo_resync(o_tx_fifo_resync));

    tni_host_model host (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_hold(hold),
        .i_out_valid(o_out_valid), .i_out_data(o_out_data), .i_out_null(o_out_null),
        .o_out_ready(i_out_ready));

    initial
    begin
        forever #2 i_core_clk = ~i_core_clk;
    end

    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Hang guard
    always @(posedge i_core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            complete_run();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        i_reg_wr <= 1'h1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_core_clk);
        i_reg_wr <= 1'h0;
        #1 check(32'(o_reg_ack), 32'h1);
    endtask

    task automatic reg_rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge i_core_clk);
        i_reg_rd <= 1'h1;
        i_reg_addr <= a;
        @(posedge i_core_clk);
        i_reg_rd <= 1'h0;
        #1 check(32'(o_reg_ack), 32'h1);
        check(32'(o_reg_rdata), 32'(exp));
    endtask

    // Offer one sample for up to four cycles
    task automatic push(input logic [31:0] d, output logic took);
        logic r;
        took = 1'h0;
        @(posedge i_core_clk);
        i_smp_valid <= 1'h1;
        i_smp_data <= d;
        for (int k = 0; k < 4 && !took; k++)
        begin
            #1 r = o_smp_ready;
            @(posedge i_core_clk);
            took = r;
        end
        i_smp_valid <= 1'h0;
    endtask

    task automatic wait_q(input int cnt);
        for (int k = 0; k < 200 && host.q.size() < cnt; k++)
            @(posedge i_core_clk);
    endtask

    // Skip inserted nulls, which must be all zero, then take one data word
    task automatic get_data(output logic [31:0] d);
        d = 32'hDEADBEEF;
        for (int k = 0; k < 200; k++)
        begin
            wait_q(1);
            e = host.q.pop_front();
            if (e[32] === 1'h0)
            begin
                d = e[31:0];
                break;
            end
            check(e[31:0], 32'h00000000);
        end
    endtask

    logic [7:0] wv[3] = '{8'hFF, 8'hFF, 8'hFF};
    logic [7:0] rv[3] = '{8'h7F, 8'hDF, 8'h3F};
    logic [7:0] rc[3] = '{8'h01, 8'h12, 8'h0C};
    logic [5:0] pw[4] = '{6'h14, 6'h10, 6'h18, 6'h20};
    logic [5:0] cw[4] = '{6'h08, 6'h10, 6'h18, 6'h20};
    logic [2:0] bpos[4] = '{3'h3, 3'h0, 3'h7, 3'h3};
    logic [1:0] bres[4] = '{2'h1, 2'h2, 2'h2, 2'h3};
    logic [31:0] bin[4] = '{32'hA5A5A5A5, 32'hA5A5A5A5, 32'h00000000, 32'hA5A5A5A5};
    logic [31:0] bout[4] = '{32'hA508A5A5, 32'hA5A501A5, 32'h00008000, 32'hA5A5A5A5};
    logic [31:0] d;

    initial
    begin
        repeat (12) @(posedge i_core_clk);
        i_sys_rst <= 1'h0;
        // Reset values and unmapped read
        reg_rd(16'h2505, 8'h04);
        reg_rd(16'h2506, 8'hCC);
        reg_rd(16'h2507, 8'h3F);
        reg_rd(16'h2508, 8'h00);
        check(32'(o_playback_link_width), 32'h20);
        for (int i = 0; i < 3; i++)
        begin
            reg_wr(TNI_ADDR_ISO_CTRL + 16'(i), wv[i]);
            reg_rd(TNI_ADDR_ISO_CTRL + 16'(i), rv[i]);
        end
        for (int i = 0; i < 3; i++)
        begin
            reg_wr(16'h2506, rc[i]);
            reg_rd(16'h2506, 8'hC0 | rc[i]);
        end
        for (int i = 0; i < 4; i++)
        begin
            reg_wr(16'h2507, 8'(i * 8'h15));
            @(posedge i_core_clk);
            #1 check(32'(o_playback_link_width), 32'(pw[i]));
            check(32'(o_capture_link_width), 32'(cw[i]));
            check(32'(o_digital_out_resolution), 32'(i));
        end
        // Native: fill until refused, then drain unchanged
        reg_wr(16'h2505, 8'h04);
        n = 0;
        ok = 1'h1;
        while (ok && n < DEPTH + 4)
        begin
            push(32'h10000000 + 32'(n), ok);
            if (ok)
                n++;
        end
        check(32'(n), 32'(DEPTH + 1));
        hold <= 1'h0;
        wait_q(DEPTH + 1);
        for (int i = 0; i < DEPTH + 1; i++)
        begin
            e = host.q.pop_front();
            check({31'h0, e[32]}, 32'h0);
            check(e[31:0], 32'h10000000 + 32'(i));
        end
        // Resync discards and gates the FIFO
        hold <= 1'h1;
        for (int i = 0; i < 3; i++)
            push(32'h20000000 + 32'(i), ok);
        reg_wr(16'h2505, 8'h40);
        @(posedge i_core_clk);
        #1 check(32'(o_tx_fifo_resync), 32'h1);
        check(32'(o_smp_ready), 32'h0);
        check(32'(o_out_valid), 32'h0);
        push(32'h30000000, ok);
        check(32'(ok), 32'h0);
        reg_wr(16'h2505, 8'h04);
        hold <= 1'h0;
        repeat (10) @(posedge i_core_clk);
        check(32'(o_tx_fifo_resync), 32'h0);
        check(32'(host.q.size()), 32'h0);
        push(32'h40000000, ok);
        get_data(d);
        check(d, 32'h40000000);
        // 96k stream at a 24 kHz setting: null and data alternate
        hold <= 1'h1;
        reg_wr(16'h2506, 8'h08);
        reg_wr(16'h2505, 8'h06);
        push(32'h5000000A, ok);
        push(32'h5000000B, ok);
        hold <= 1'h0;
        wait_q(4);
        check(host.q[0][31:0], 32'h00000000);
        check({31'h0, host.q[0][32]}, 32'h1);
        check(host.q[1][31:0], 32'h5000000A);
        check({31'h0, host.q[2][32]}, 32'h1);
        check(host.q[3][31:0], 32'h5000000B);
        check({31'h0, host.q[3][32]}, 32'h0);
        // Byte-null style, only with an isochronous mode
        reg_wr(16'h2506, 8'h0C);
        for (int i = 0; i < 4; i++)
        begin
            reg_wr(16'h2507, 8'h3C | 8'(bres[i]));
            reg_wr(16'h2505, {2'h0, bpos[i], 2'h1, i[0]});
            host.q.delete();
            push(bin[i], ok);
            get_data(d);
            check(d, bout[i]);
        end
        complete_run();
    end
endmodule
